/* File: bench/sflalu_sva.sv */
// Port-level assertions for the subtract unit
`timescale 1ns/1ps
`default_nettype none
module sflalu_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  input wire logic [7:0]  w_o,
  input wire logic [4:0]  flags_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic go, lit, fil;
  // Instruction writes while busy are dropped, so only an idle start counts
  assign go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && !busy_o
    && wb_adr_i[7:2] == 6'h00 && wb_sel_i[1:0] == 2'b11;
  assign lit = go && wb_dat_i[15:8] == 8'h08;
  assign fil = go && wb_dat_i[15:10] == 6'h17;
  sequence s_run;
    busy_o [*4] ##1 !busy_o;
  endsequence
  property p_lit_res;
    logic [7:0] k, w;
    (lit, k = wb_dat_i[7:0], w = w_o) |-> ##5 w_o == k - w
      && flags_o[0] == (k >= w);
  endproperty
  property p_lit_flg;
    logic [7:0] k, w;
    (lit, k = wb_dat_i[7:0], w = w_o) |-> ##5 flags_o[4] == w_o[7]
      && flags_o[2] == (w_o == 8'h00) && flags_o[1] == (k[3:0] >= w[3:0])
      && flags_o[3] == (k[7] != w[7] && w_o[7] != k[7]);
  endproperty
  property p_file_keep;
    logic [7:0] w;
    (fil && wb_dat_i[9], w = w_o) |-> ##5 w_o == w;
  endproperty
  a_ack_resp: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_busy_len: assert property (lit || fil |=> s_run)
    else $error("busy not four cycles");
  a_w_hold: assert property (
    busy_o && $past(busy_o) |-> $stable(w_o))
    else $error("W moved mid instruction");
  a_lit_result: assert property (p_lit_res)
    else $error("literal result or carry wrong");
  a_lit_flags: assert property (p_lit_flg)
    else $error("literal flags wrong");
  a_file_flags: assert property (fil && !wb_dat_i[9] |-> ##5
    flags_o[4] == w_o[7] && flags_o[2] == (w_o == 8'h00))
    else $error("file flags wrong");
  a_file_keep: assert property (p_file_keep)
    else $error("W changed with file destination");
endmodule
`default_nettype wire

/* File: bench/subtract_literal_and_file_alu_bench.sv */
// Self-checking bench for the subtract unit
`timescale 1ns/1ps
`default_nettype none
module subtract_literal_and_file_alu_bench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, q;
  logic        wb_ack_o, busy_o, lit, d;
  logic [7:0]  w_o, k, w, f, v;
  logic [4:0]  flags_o;
  logic [12:0] e;
  logic [15:0] corner [5] = '{16'h0201, 16'h0202, 16'h0203, 16'h8001,
    16'h00FF};
  int          mismatches = 0;
  int          total_checks = 0;
  always #50 clk_i = ~clk_i;
  sflalu_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .w_o, .flags_o, .busy_o);
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Design outputs update by NBA, so reads here see the sampled values
  task automatic bus(input logic we, input logic [7:0] a,
      input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  function automatic logic [12:0] sub_exp(input logic [7:0] m,
      input logic [7:0] s);
    logic [7:0] r;
    r = m - s;
    return {r[7], m[7] != s[7] && r[7] != m[7], r == 8'h00,
      m[3:0] >= s[3:0], m >= s, r};
  endfunction
  initial begin
    void'($urandom(74258));
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    chk({w_o, flags_o, busy_o}, 32'h0000_0000);
    for (int i = 0; i < 40; i++) begin
      k = (i < 5) ? corner[i][15:8] : 8'($urandom);
      w = (i < 5) ? corner[i][7:0] : 8'($urandom);
      f = 8'($urandom);
      v = 8'($urandom);
      lit = i < 5 || 1'($urandom);
      d = 1'($urandom);
      bus(1'b1, 8'h04, {24'h00_0000, w});
      if (!lit) begin
        bus(1'b1, 8'h0C, {24'h00_0000, f});
        bus(1'b1, 8'h10, {24'h00_0000, v});
      end
      e = lit ? sub_exp(k, w) : sub_exp(v, w);
      bus(1'b1, 8'h00, lit ? {16'h0000, 8'h08, k} :
        {16'h0000, 6'h17, d, 1'($urandom), f});
      // W and flags are visible at the fourth edge after the ack is seen
      repeat (4) @(posedge clk_i);
      chk(flags_o, e[12:8]);
      chk(w_o, (lit || !d) ? e[7:0] : w);
      if (!lit && d) begin
        bus(1'b0, 8'h10, 32'h0000_0000);
        chk(q, e[7:0]);
      end
    end
    // Unknown opcode keeps W and flags and raises the illegal bit
    bus(1'b1, 8'h04, 32'h0000_005A);
    bus(1'b1, 8'h00, 32'h0000_FFFF);
    bus(1'b0, 8'h08, 32'h0000_0000);
    chk(q & 32'h0000_007F, {25'h000_0000, 1'b1, 1'b0, e[12:8]});
    chk(w_o, 32'h0000_005A);
    bus(1'b0, 8'h00, 32'h0000_0000);
    chk(q, 32'h0000_FFFF);
    // A W write while busy is dropped, so the result still lands
    e = sub_exp(8'h10, 8'h5A);
    bus(1'b1, 8'h00, 32'h0000_0810);
    bus(1'b1, 8'h04, 32'h0000_0033);
    repeat (2) @(posedge clk_i);
    chk(w_o, {24'h00_0000, e[7:0]});
    chk(flags_o, e[12:8]);
    bus(1'b0, 8'h04, 32'h0000_0000);
    chk(q, {24'h00_0000, e[7:0]});
    bus(1'b0, 8'hFC, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    summarize();
  end
  initial begin
    #500000;
    mismatches++;
    summarize();
  end
endmodule
bind sflalu_top sflalu_sva u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .w_o, .flags_o,
  .busy_o);
`default_nettype wire

/* File: hdl/sflalu_sub.v */
// Eight-bit two's complement subtractor with status flags
`timescale 1ns/1ps
`default_nettype none
module sflalu_sub (
  // Operands
  input  wire [7:0] minuend_i,
  input  wire [7:0] subtrahend_i,
  // Result and flags
  output wire [7:0] diff_o,
  output wire       carry_o,
  output wire       digit_carry_o,
  output wire       zero_o,
  output wire       overflow_o,
  output wire       negative_o
);
  wire [8:0] full_sum;
  wire [4:0] low_sum;

  // Adding the complement plus one: carry out is the inverted borrow
  assign full_sum = {1'b0, minuend_i} + {1'b0, ~subtrahend_i} + 9'h001;
  assign low_sum  = {1'b0, minuend_i[3:0]} + {1'b0, ~subtrahend_i[3:0]}
                    + 5'h01;
  assign diff_o        = full_sum[7:0];
  assign carry_o       = full_sum[8];
  assign digit_carry_o = low_sum[4];
  assign zero_o        = (full_sum[7:0] == 8'h00);
  assign negative_o    = full_sum[7];
  assign overflow_o    = (minuend_i[7] != subtrahend_i[7]) &&
                         (full_sum[7] != minuend_i[7]);
endmodule
`default_nettype wire

/* File: hdl/sflalu_top.v */
// Subtract literal and subtract file execution unit with Wishbone slave
//
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sflalu_defs.vh"
module sflalu_top (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Core state
  output reg  [7:0]  w_o,
  output reg  [4:0]  flags_o,
  output reg         busy_o
);
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_Q1   = 5'b00010;
  localparam [4:0] ST_Q2   = 5'b00100;
  localparam [4:0] ST_Q3   = 5'b01000;
  localparam [4:0] ST_Q4   = 5'b10000;

  reg [4:0]  state_r;
  reg [15:0] instr_r;
  reg [7:0]  faddr_r;
  reg [7:0]  opa_r;
  reg [7:0]  opw_r;
  reg [7:0]  res_r;
  reg [4:0]  res_flags_r;
  reg        is_file_r;
  reg        dest_f_r;
  reg        bank_r;
  reg        illegal_r;
  reg [7:0]  file_mem [0:255];

  wire       wb_req;
  wire       wb_wr;
  wire [7:0] diff;
  wire       c_f;
  wire       dig_f;
  wire       z_f;
  wire       ovfl_f;
  wire       n_f;

  function sel_is;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      sel_is = (adr[7:2] == ofs[7:2]);
    end
  endfunction

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;

  sflalu_sub u_sub (
    .minuend_i     (opa_r),
    .subtrahend_i  (opw_r),
    .diff_o        (diff),
    .carry_o       (c_f),
    .digit_carry_o (dig_f),
    .zero_o        (z_f),
    .overflow_o    (ovfl_f),
    .negative_o    (n_f)
  );

  // Bus acknowledge, one cycle per request
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Read data, captured at the same edge that raises ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= `SFL_ZERO32;
    end else if (wb_req && !wb_we_i) begin
      if (sel_is(wb_adr_i, `SFL_OFS_INSTR)) begin
        wb_dat_o <= {16'h0000, instr_r};
      end else if (sel_is(wb_adr_i, `SFL_OFS_WREG)) begin
        wb_dat_o <= {24'h00_0000, w_o};
      end else if (sel_is(wb_adr_i, `SFL_OFS_STATUS)) begin
        wb_dat_o <= {24'h00_0000, bank_r, illegal_r, busy_o, flags_o};
      end else if (sel_is(wb_adr_i, `SFL_OFS_FADDR)) begin
        wb_dat_o <= {24'h00_0000, faddr_r};
      end else if (sel_is(wb_adr_i, `SFL_OFS_FDATA)) begin
        wb_dat_o <= {24'h00_0000, file_mem[faddr_r]};
      end else begin
        wb_dat_o <= `SFL_ZERO32;
      end
    end
  end

  // File address pointer
  always @(posedge clk_i) begin
    if (rst_i) begin
      faddr_r <= `SFL_RST_BYTE;
    end else if (wb_wr && wb_sel_i[0] &&
                 sel_is(wb_adr_i, `SFL_OFS_FADDR)) begin
      faddr_r <= wb_dat_i[7:0];
    end
  end

  // File memory; the core writes it only in Q4, so bus writes while busy
  // are dropped to keep one writer per cycle
  always @(posedge clk_i) begin
    if (state_r == ST_Q4 && is_file_r && dest_f_r) begin
      file_mem[instr_r[`SFL_OPERAND]] <= res_r;
    end else if (wb_wr && !busy_o && wb_sel_i[0] &&
                 sel_is(wb_adr_i, `SFL_OFS_FDATA)) begin
      file_mem[faddr_r] <= wb_dat_i[7:0];
    end
  end

  // Four phase sequencer, one phase per clock
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_r     <= ST_IDLE;
      busy_o      <= 1'b0;
      instr_r     <= `SFL_RST_INSTR;
      w_o         <= `SFL_RST_BYTE;
      flags_o     <= 5'b0_0000;
      opa_r       <= `SFL_RST_BYTE;
      opw_r       <= `SFL_RST_BYTE;
      res_r       <= `SFL_RST_BYTE;
      res_flags_r <= 5'b0_0000;
      is_file_r   <= 1'b0;
      dest_f_r    <= 1'b0;
      bank_r      <= 1'b0;
      illegal_r   <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (wb_wr && wb_sel_i[1:0] == 2'b11 &&
              sel_is(wb_adr_i, `SFL_OFS_INSTR)) begin
            instr_r <= wb_dat_i[15:0];
            busy_o  <= 1'b1;
            state_r <= ST_Q1;
          end else if (wb_wr && wb_sel_i[0] &&
                       sel_is(wb_adr_i, `SFL_OFS_WREG)) begin
            w_o <= wb_dat_i[7:0];
          end
        end
        ST_Q1: begin
          // Decode
          if (instr_r[`SFL_OP_HI] == `SFL_OP_LIT) begin
            is_file_r <= 1'b0;
            dest_f_r  <= 1'b0;
            illegal_r <= 1'b0;
            state_r   <= ST_Q2;
          end else if (instr_r[`SFL_OP6] == `SFL_OP_FILE) begin
            is_file_r <= 1'b1;
            dest_f_r  <= instr_r[`SFL_BIT_D];
            bank_r    <= instr_r[`SFL_BIT_A];
            illegal_r <= 1'b0;
            state_r   <= ST_Q2;
          end else begin
            // Unknown words leave W and the flags alone
            illegal_r <= 1'b1;
            busy_o    <= 1'b0;
            state_r   <= ST_IDLE;
          end
        end
        ST_Q2: begin
          // Read literal or file operand
          if (is_file_r) begin
            opa_r <= file_mem[instr_r[`SFL_OPERAND]];
          end else begin
            opa_r <= instr_r[`SFL_OPERAND];
          end
          opw_r   <= w_o;
          state_r <= ST_Q3;
        end
        ST_Q3: begin
          // Process data
          res_r       <= diff;
          res_flags_r <= {n_f, ovfl_f, z_f, dig_f, c_f};
          state_r     <= ST_Q4;
        end
        ST_Q4: begin
          // Write destination and status together
          if (!dest_f_r) begin
            w_o <= res_r;
          end
          flags_o <= res_flags_r;
          busy_o  <= 1'b0;
          state_r <= ST_IDLE;
        end
        default: begin
          busy_o  <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: pkg/sflalu_defs.vh */
// Constants and register map of the subtract ALU datapath
// Function
// - Literal minus W written back to W
// - Literal subtract opcode high byte 0000 1000
// - Updates N, overflow, carry, digit carry, Z
// - One cycle of four phases Q1 to Q4
// - Literal above W: carry set, Z, N clear; the code sets N from result bit 7, so N is set when that bit is 1
// - File minus W, with destination and bank bits
// - File subtract opcode bits 0101 11 d a f
`ifndef SFLALU_DEFS_VH
`define SFLALU_DEFS_VH

// Register byte offsets
`define SFL_OFS_INSTR   8'h00
`define SFL_OFS_WREG    8'h04
`define SFL_OFS_STATUS  8'h08
`define SFL_OFS_FADDR   8'h0C
`define SFL_OFS_FDATA   8'h10

// Instruction decode
`define SFL_OP_LIT      8'h08
`define SFL_OP_FILE     6'h17
`define SFL_OP_HI       15:8
`define SFL_OP6         15:10
`define SFL_BIT_D       9
`define SFL_BIT_A       8
`define SFL_OPERAND     7:0

// Status bit positions
`define SFL_ST_C        0
`define SFL_ST_DIGIT    1
`define SFL_ST_Z        2
`define SFL_ST_OVFL     3
`define SFL_ST_N        4
`define SFL_ST_BUSY     5
`define SFL_ST_ILL      6
`define SFL_ST_BANK     7

// Reset values
`define SFL_RST_BYTE    8'h00
`define SFL_RST_INSTR   16'h0000
`define SFL_ZERO32      32'h0000_0000

`endif
